/* awf_pkg.sv */
/*
  awf_pkg: constants and carriers of the output word formatter.
  assumes: included before the design module; no imports are made.
*/
`default_nettype none
package awf_pkg;
  // register port
  localparam int unsigned ADDR_W      = 4;
  localparam logic [3:0] OFF_CFG0     = 4'h0;   // trim field in bits 7:0
  localparam logic [3:0] OFF_CFG1     = 4'h1;   // reference select, bit 0
  localparam logic [3:0] OFF_STATCOM  = 4'h2;   // width and oversampling select
  localparam logic [3:0] OFF_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFF_RESULT   = 4'h5;   // last formatted word
  // field positions
  localparam int unsigned POS_WIDTH   = 0;      // 2 bits
  localparam int unsigned POS_OSR     = 4;      // 3 bits
  localparam int unsigned POS_EXTREF  = 0;
  // reset values
  localparam logic [7:0] RST_TRIM     = 8'h50;
  localparam logic [1:0] RST_WIDTH    = 2'h1;   // 24-bit format
  localparam logic [2:0] RST_OSR      = 3'h3;
  localparam logic       RST_EXTREF   = 1'b0;
  // codes
  localparam int unsigned RES_W       = 24;
  localparam logic [23:0] CODE_POS_FS = 24'h7fffff;
  localparam logic [23:0] CODE_NEG_FS = 24'h800000;
  // interrupt bits
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_READY   = 0;
  localparam int unsigned IRQ_POS_SAT = 1;
  localparam int unsigned IRQ_NEG_SAT = 2;

  typedef enum logic [1:0] {
    AWF_W16 = 2'h0,
    AWF_W24 = 2'h1,
    AWF_W32S = 2'h2,
    AWF_W32Z = 2'h3
  } awf_width_t;

  // one filter result arriving from the decimator
  typedef struct packed {
    logic        valid;
    logic        pos_sat;
    logic        neg_sat;
    logic [23:0] value;
  } awf_sample_t;

  // one formatted word leaving the block
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } awf_word_t;
endpackage : awf_pkg
`default_nettype wire

/* awf_formatter.sv */
/*
  awf_formatter: output-coding stage of a multi-channel delta-sigma converter.
  assumes: one clock (clk_sys), asynchronous active-low reset, results come one
  channel at a time, synchronous to clk_sys, with the channel index beside them.
*/
// Added by the designer: the address-and-strobe port and the placing of the registers.
// What this block does
// - results are 24-bit two's complement, sign plus 23 bits, msb first
// - output word reformatted to 16, 24 or 32 bits by the width setting
// - 24-bit format is default; other formats rescale the value
// - positive overrange clamps to the maximum positive code
// - negative overrange clamps to the most negative code
// - 24-bit word right justified and sign extended, zeros in unused low bits
// - one resolution for all channels from the shared oversampling select
// - oversampling 256 and above keeps all 24 bits
// - oversampling 128 gives 23 bits, bit 0 forced to zero
// - oversampling 64 gives 20 bits, four low bits forced to zero
// - oversampling 32 gives 17 bits, seven low bits forced to zero
// - reference select at zero, the default, uses the internal reference
// - reference select at one turns reference pins into a differential input
// - 8-bit tempco trim field sits in bits 7 to 0 of first config register
// - the trim field loads 0x50 at reset
// - resolution depends only on oversampling select: 17, 20, 23, then 24
`default_nettype none
module awf_formatter #(
  parameter int unsigned CHANNELS = 2,
  parameter int unsigned CH_W     = 1
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // filter results
  input  wire awf_pkg::awf_sample_t     sample,
  input  wire logic [CH_W-1:0]          sample_ch,
  // formatted words
  output var  awf_pkg::awf_word_t       out_word,
  output logic [CH_W-1:0]               out_ch,
  // register port
  input  wire logic [awf_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic [31:0]                   reg_rdata,
  // reference control and interrupt
  output logic                          external_reference_select,
  output logic [7:0]                    reference_tempco_trim,
  output logic                          irq
);

  initial
  begin
    if (CHANNELS < 1 || CHANNELS > (1 << CH_W))
      $error("CHANNELS does not fit CH_W");
    // a zero-width channel index cannot be declared
    if (CH_W < 1)
      $error("CH_W must be at least one");
    // the clamp codes and masks are all 24 bits wide
    if (awf_pkg::RES_W != 24)
      $error("result width must stay at 24 bits");
  end

  // configuration, status and result state
  logic [1:0]  width_sel;
  logic [2:0]  oversampling_ratio_select;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_mask;
  logic [31:0] last_word;

  // low-bit mask for the shared resolution, one decode for all channels
  function automatic logic [23:0] awf_res_mask(input logic [2:0] osr);
    case (osr)
      3'h0:    awf_res_mask = 24'hffff80; // 17 bits
      3'h1:    awf_res_mask = 24'hfffff0; // 20 bits
      3'h2:    awf_res_mask = 24'hfffffe; // 23 bits
      default: awf_res_mask = 24'hffffff; // 24 bits
    endcase
  endfunction : awf_res_mask

  // clamp first so the full-scale codes are masked like any other result
  wire logic [23:0] clamped =
    sample.pos_sat ? awf_pkg::CODE_POS_FS :
    sample.neg_sat ? awf_pkg::CODE_NEG_FS :
    sample.value;
  wire logic [23:0] res_mask = awf_res_mask(oversampling_ratio_select);
  wire logic [23:0] masked   = clamped & res_mask;

  // width reformatting; 16-bit drops low byte, 32-bit scales by 256
  // the 16-bit form loses the low byte, so masked low bits vanish there
  wire logic [31:0] word_w16 = {{16{masked[23]}}, masked[23:8]};
  wire logic [31:0] word_w24 = {{8{masked[23]}}, masked};
  wire logic [31:0] word_w32 = {masked, 8'h00};
  // both 32-bit codes give the same shifted word
  wire logic [31:0] next_word =
    (width_sel == awf_pkg::AWF_W16) ? word_w16 :
    (width_sel == awf_pkg::AWF_W24) ? word_w24 :
                                      word_w32;

  // register decode
  wire logic wr_cfg0 = reg_wr && reg_addr == awf_pkg::OFF_CFG0;
  wire logic wr_cfg1 = reg_wr && reg_addr == awf_pkg::OFF_CFG1;
  wire logic wr_stat = reg_wr && reg_addr == awf_pkg::OFF_STATCOM;
  wire logic wr_iclr = reg_wr && reg_addr == awf_pkg::OFF_IRQ_STAT;
  wire logic wr_imsk = reg_wr && reg_addr == awf_pkg::OFF_IRQ_MASK;
  wire logic [2:0] events = {sample.valid & sample.neg_sat,
                             sample.valid & sample.pos_sat, sample.valid};
  // set wins over a write-one clear in the same cycle
  wire logic [2:0] next_irq_stat = (irq_stat & ~(wr_iclr ? reg_wdata[2:0] : 3'h0)) | events;
  wire logic [31:0] rd_mux =
    (reg_addr == awf_pkg::OFF_CFG0)     ? {24'h000000, reference_tempco_trim} :
    (reg_addr == awf_pkg::OFF_CFG1)     ? {31'h00000000, external_reference_select} :
    (reg_addr == awf_pkg::OFF_STATCOM)  ? {25'h0000000, oversampling_ratio_select,
                                           2'h0, width_sel} :
    (reg_addr == awf_pkg::OFF_IRQ_STAT) ? {29'h00000000, irq_stat} :
    (reg_addr == awf_pkg::OFF_IRQ_MASK) ? {29'h00000000, irq_mask} :
    (reg_addr == awf_pkg::OFF_RESULT)   ? last_word : 32'h00000000;

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reference_tempco_trim     <= awf_pkg::RST_TRIM;
      external_reference_select <= awf_pkg::RST_EXTREF;
      width_sel                 <= awf_pkg::RST_WIDTH;
      oversampling_ratio_select <= awf_pkg::RST_OSR;
      irq_mask                  <= 3'h0;
    end
    else
    begin
      if (wr_cfg0)
        reference_tempco_trim <= reg_wdata[7:0];
      if (wr_cfg1)
        external_reference_select <= reg_wdata[awf_pkg::POS_EXTREF];
      if (wr_stat)
      begin
        width_sel                 <= reg_wdata[awf_pkg::POS_WIDTH +: 2];
        oversampling_ratio_select <= reg_wdata[awf_pkg::POS_OSR +: 3];
      end
      if (wr_imsk)
        irq_mask <= reg_wdata[2:0];
    end
  end

  // data path, status and read port
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_word  <= '0;
      out_ch    <= '0;
      last_word <= 32'h00000000;
      irq_stat  <= 3'h0;
      irq       <= 1'b0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      out_word.valid <= sample.valid;
      if (sample.valid)
      begin
        out_word.word <= next_word;
        out_ch        <= sample_ch;
        last_word     <= next_word;
      end
      irq_stat  <= next_irq_stat;
      irq       <= |(next_irq_stat & irq_mask);
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // assertions
  chk_pos_clamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.pos_sat && width_sel == awf_pkg::AWF_W24
      |=> out_word.valid && out_word.word[23:0] == (awf_pkg::CODE_POS_FS & $past(res_mask)))
    else $error("positive saturation not clamped");
  chk_neg_clamp: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.neg_sat && width_sel == awf_pkg::AWF_W24
      |=> out_word.word == 32'hff800000)
    else $error("negative saturation not clamped");
  chk_osr_128: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && oversampling_ratio_select == 3'h2 && width_sel == awf_pkg::AWF_W24
      |=> out_word.word[0] == 1'b0)
    else $error("bit 0 not cleared at 23-bit resolution");
  chk_osr_64: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && oversampling_ratio_select == 3'h1 && width_sel == awf_pkg::AWF_W24
      |=> out_word.word[3:0] == 4'h0)
    else $error("low nibble not cleared at 20-bit resolution");
  chk_osr_32: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && oversampling_ratio_select == 3'h0 && width_sel == awf_pkg::AWF_W24
      |=> out_word.word[6:0] == 7'h00)
    else $error("low bits not cleared at 17-bit resolution");
  chk_full_res: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && !sample.pos_sat && !sample.neg_sat && oversampling_ratio_select[2]
      && width_sel == awf_pkg::AWF_W24 |=> out_word.word[23:0] == $past(sample.value))
    else $error("24-bit result altered");
  chk_w16_scale: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && width_sel == awf_pkg::AWF_W16
      |=> out_word.word[15:0] == $past(masked[23:8]))
    else $error("16-bit format wrong");
  chk_trim_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_cfg0 |=> reference_tempco_trim == $past(reg_wdata[7:0]))
    else $error("trim field not written");
  chk_irq_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.pos_sat |=> irq_stat[awf_pkg::IRQ_POS_SAT])
    else $error("saturation event lost");

  // named steps shared by the format checks
  sequence s_take;
    sample.valid;
  endsequence
  sequence s_take_w24;
    sample.valid && width_sel == awf_pkg::AWF_W24;
  endsequence
  sequence s_take_w32;
    sample.valid && width_sel[1];
  endsequence
  sequence s_idle;
    !sample.valid;
  endsequence

  // every taken result leaves as one word
  chk_valid_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take
      |=> out_word.valid)
    else $error("result word not issued");

  // no word appears without a result behind it
  chk_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_idle
      |=> !out_word.valid)
    else $error("spurious result word");

  // channel index travels with its word
  chk_chan_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take
      |=> out_ch == $past(sample_ch))
    else $error("channel index lost");

  // word and channel hold between results, readers may be slow
  chk_word_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_idle
      |=> $stable(out_word.word) && $stable(out_ch))
    else $error("result word changed while idle");

  // result register mirrors the issued word
  chk_last_word: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take
      |=> last_word == out_word.word)
    else $error("result register out of step");

  // 24-bit form is sign extended into the top byte
  chk_w24_sign: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w24
      |=> out_word.word[31:24] == {8{out_word.word[23]}})
    else $error("24-bit word not sign extended");

  // bits below the resolution always read as zero
  chk_mask_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w24
      |=> (out_word.word[23:0] & ~$past(res_mask)) == 24'h000000)
    else $error("unused low bits not zero");

  // 32-bit forms carry a zero low byte
  chk_w32_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w32
      |=> out_word.word[7:0] == 8'h00)
    else $error("32-bit low byte not zero");

  // 32-bit forms scale the 24-bit code by 256
  chk_w32_scale: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w32
      |=> out_word.word[31:8] == ($past(clamped) & $past(res_mask)))
    else $error("32-bit scale wrong");

  // 16-bit form is sign extended into the top half
  chk_w16_sign: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && width_sel == awf_pkg::AWF_W16
      |=> out_word.word[31:16] == {16{out_word.word[15]}})
    else $error("16-bit word not sign extended");

  // positive clamp wins when both flags arrive together
  chk_pos_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w24 and sample.pos_sat && sample.neg_sat
      |=> out_word.word[23:0] == (awf_pkg::CODE_POS_FS & $past(res_mask)))
    else $error("clamp priority wrong");

  // most negative code survives any mask and the shift
  chk_neg_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.neg_sat && !sample.pos_sat && width_sel[1]
      |=> out_word.word == {awf_pkg::CODE_NEG_FS, 8'h00})
    else $error("negative clamp lost in 32-bit form");

  // clamped codes in 16-bit form keep the top half only
  chk_pos_w16: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.pos_sat && width_sel == awf_pkg::AWF_W16
      |=> out_word.word == 32'h00007fff)
    else $error("positive clamp wrong in 16-bit form");
  chk_neg_w16: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.neg_sat && !sample.pos_sat && width_sel == awf_pkg::AWF_W16
      |=> out_word.word == 32'hffff8000)
    else $error("negative clamp wrong in 16-bit form");

  // the lowest full-resolution code keeps every bit
  chk_osr_top: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take_w24 and !sample.pos_sat && !sample.neg_sat && oversampling_ratio_select == 3'h3
      |=> out_word.word[23:0] == $past(sample.value))
    else $error("24-bit code altered at lowest full ratio");

  // reference select follows a write of its register
  chk_extref_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_cfg1
      |=> external_reference_select == $past(reg_wdata[awf_pkg::POS_EXTREF]))
    else $error("reference select not written");

  // reference select moves only on its own write
  chk_extref_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wr_cfg1
      |=> $stable(external_reference_select))
    else $error("reference select changed unasked");

  // trim keeps its value unless written
  chk_trim_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wr_cfg0
      |=> $stable(reference_tempco_trim))
    else $error("trim changed unasked");

  // one shared setting for every channel
  chk_cfg_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_stat
      |=> width_sel == $past(reg_wdata[1:0])
          && oversampling_ratio_select == $past(reg_wdata[6:4]))
    else $error("format setting not written");

  // read data only in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd
      |=> reg_rdata == 32'h00000000)
    else $error("read data outside a read");

  // trim readback sits in the low byte
  chk_rd_trim: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == awf_pkg::OFF_CFG0
      |=> reg_rdata == {24'h000000, $past(reference_tempco_trim)})
    else $error("trim readback wrong");

  // result readback returns the last issued word
  chk_rd_result: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == awf_pkg::OFF_RESULT
      |=> reg_rdata == $past(last_word))
    else $error("result readback wrong");

  // ready status set by every result
  chk_ready_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_take
      |=> irq_stat[awf_pkg::IRQ_READY])
    else $error("ready event lost");

  // negative saturation status set by its event
  chk_neg_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    sample.valid && sample.neg_sat
      |=> irq_stat[awf_pkg::IRQ_NEG_SAT])
    else $error("negative saturation event lost");

  // a write of ones clears when no event competes
  chk_stat_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_iclr && !sample.valid
      |=> (irq_stat & $past(reg_wdata[2:0])) == 3'h0)
    else $error("status not cleared");

  // status bits stay set until cleared
  chk_stat_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wr_iclr
      |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit dropped");

  // interrupt level tracks status under the mask
  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    1'b1
      |-> irq == |(irq_stat & $past(irq_mask)))
    else $error("interrupt level wrong");

endmodule : awf_formatter
`default_nettype wire

/* awf_formatter_tb.sv */
/*
  awf_formatter_tb: self-checking bench for the output word formatter.
  assumes: awf_pkg and awf_formatter are compiled first; assertions sit in the design.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys = 1'b0;
  logic                 rst_b = 1'b0;
  awf_pkg::awf_sample_t sample = '0;
  logic [0:0]           sample_ch = 1'h0;
  awf_pkg::awf_word_t   out_word;
  logic [0:0]           out_ch;
  logic [3:0]           reg_addr = 4'h0;
  logic [31:0]          reg_wdata = 32'h0;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [31:0]          reg_rdata;
  logic                 external_reference_select;
  logic [7:0]           reference_tempco_trim;
  logic                 irq;
  logic [31:0]          rd;
  int                   n_fail = 0;
  int                   num_checks = 0;

  awf_formatter #(.CHANNELS(2), .CH_W(1)) awf_formatter_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .sample(sample), .sample_ch(sample_ch),
    .out_word(out_word), .out_ch(out_ch), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_reference_select(external_reference_select),
    .reference_tempco_trim(reference_tempco_trim), .irq(irq));

  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp_v);
    num_checks++;
    if (seen !== exp_v)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp_v, seen);
    end
  endtask : check

  // one-cycle strobes, changed right after the edge
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  // one result in, word checked the cycle after
  task automatic send(input logic [23:0] v, input logic ps, input logic ns, input logic ch,
                      input logic [31:0] exp_w);
    @(posedge clk_sys);
    sample    <= '{valid: 1'b1, pos_sat: ps, neg_sat: ns, value: v};
    sample_ch <= ch;
    @(posedge clk_sys);
    sample    <= '0;
    #1;
    check("out valid", {31'h0, out_word.valid}, 32'h1);
    check("out word", out_word.word, exp_w);
    check("out chan", {31'h0, out_ch}, {31'h0, ch});
    @(posedge clk_sys);
    #1;
    check("out pulse", {31'h0, out_word.valid}, 32'h0);
  endtask : send

  // expected word: mask first, then width; clamp codes come from the caller
  function automatic logic [31:0] fmt(input logic [23:0] v, input logic [2:0] o,
                                      input logic [1:0] w);
    logic [23:0] m;
    m = (o == 3'h0) ? v & 24'hffff80 : (o == 3'h1) ? v & 24'hfffff0 :
        (o == 3'h2) ? v & 24'hfffffe : v;
    case (w)
      2'h0: fmt = {{16{m[23]}}, m[23:8]};
      2'h1: fmt = {{8{m[23]}}, m};
      default: fmt = {m, 8'h00};
    endcase
  endfunction : fmt

  task automatic t_reset();
    reg_read(4'h0, rd);
    check("trim rst", rd, 32'h50);
    @(posedge clk_sys);
    #1;
    check("rdata idle", reg_rdata, 32'h0);
    reg_read(4'h1, rd);
    check("cfg1 rst", rd, 32'h0);
    reg_read(4'h2, rd);
    check("statcom rst", rd, 32'h31);
    reg_read(4'hf, rd);
    check("unmapped", rd, 32'h0);
    check("trim pin", {24'h0, reference_tempco_trim}, 32'h50);
    check("ext pin", {31'h0, external_reference_select}, 32'h0);
  endtask : t_reset

  task automatic t_refs();
    reg_write(4'h1, 32'h1);
    reg_write(4'h0, 32'h142);
    settle();
    check("ext on", {31'h0, external_reference_select}, 32'h1);
    check("trim pin", {24'h0, reference_tempco_trim}, 32'h42);
    reg_read(4'h0, rd);
    check("trim rd", rd, 32'h42);
    reg_write(4'h0, 32'h50);
    settle();
    check("trim back", {24'h0, reference_tempco_trim}, 32'h50);
    reg_write(4'h1, 32'h0);
    settle();
    check("ext off", {31'h0, external_reference_select}, 32'h0);
  endtask : t_refs

  // every width and oversampling code, plus both clamps
  task automatic t_format();
    logic [23:0] vals [4] = '{24'h7fffff, 24'hffffff, 24'h123457, 24'h800001};
    for (int w = 0; w < 4; w++)
      for (int o = 0; o < 8; o++)
      begin
        reg_write(4'h2, 32'(o * 16 + w));
        for (int k = 0; k < 4; k++)
          send(vals[k], 1'b0, 1'b0, k[0], fmt(vals[k], 3'(o), 2'(w)));
        send(24'h000000, 1'b1, 1'b0, 1'b1, fmt(24'h7fffff, 3'(o), 2'(w)));
        send(24'h7fffff, 1'b0, 1'b1, 1'b0, fmt(24'h800000, 3'(o), 2'(w)));
      end
    reg_write(4'h5, 32'h0);
    reg_read(4'h5, rd);
    check("result ro", rd, fmt(24'h800000, 3'h7, 2'h3));
  endtask : t_format

  task automatic t_irq();
    reg_write(4'h2, 32'h31);
    reg_write(4'h3, 32'h7);
    reg_write(4'h4, 32'h1);
    settle();
    check("irq idle", {31'h0, irq}, 32'h0);
    send(24'h000010, 1'b0, 1'b0, 1'b0, 32'h10);
    settle();
    check("irq ready", {31'h0, irq}, 32'h1);
    reg_read(4'h3, rd);
    check("stat ready", rd, 32'h1);
    reg_write(4'h4, 32'h6);
    settle();
    check("irq masked", {31'h0, irq}, 32'h0);
    send(24'h0, 1'b1, 1'b0, 1'b0, 32'h7fffff);
    settle();
    check("irq sat", {31'h0, irq}, 32'h1);
    reg_read(4'h3, rd);
    check("stat pos", rd, 32'h3);
    send(24'h0, 1'b0, 1'b1, 1'b0, 32'hff800000);
    reg_read(4'h3, rd);
    check("stat neg", rd, 32'h7);
    reg_write(4'h3, 32'h7);
    settle();
    check("irq clr", {31'h0, irq}, 32'h0);
    // event and clear in one cycle: the event must win
    @(posedge clk_sys);
    sample    <= '{valid: 1'b1, pos_sat: 1'b0, neg_sat: 1'b0, value: 24'h0};
    reg_addr  <= 4'h3;
    reg_wdata <= 32'h1;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    sample    <= '0;
    reg_wr    <= 1'b0;
    reg_read(4'h3, rd);
    check("set wins", rd, 32'h1);
  endtask : t_irq

  // reset in mid-run restores the trim, format and reference select defaults
  task automatic t_rerst();
    reg_write(4'h0, 32'h42);
    reg_write(4'h2, 32'h0);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    reg_read(4'h0, rd);
    check("trim rerst", rd, 32'h50);
    reg_read(4'h2, rd);
    check("statcom rerst", rd, 32'h31);
    check("ext rerst", {31'h0, external_reference_select}, 32'h0);
  endtask : t_rerst

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_refs();
    t_format();
    t_irq();
    t_rerst();
    wrap_up();
  end

  // about 730 cycles of work; cut a hang well beyond that
  initial
  begin
    #200us;
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
